// [common/cpwmt_pkg.sv]
package cpwmt_pkg;
	localparam logic [7:0]  A_SC    = 8'h00;
	localparam logic [7:0]  A_CNTH  = 8'h04;
	localparam logic [7:0]  A_CNTL  = 8'h08;
	localparam logic [7:0]  A_MODH  = 8'h0c;
	localparam logic [7:0]  A_MODL  = 8'h10;
	localparam logic [7:0]  A_CH0   = 8'h14;
	localparam logic [7:0]  A_CSTEP = 8'h0c;
	localparam logic [7:0]  A_CSC   = 8'h00;
	localparam logic [7:0]  A_CVH   = 8'h04;
	localparam logic [7:0]  A_CVL   = 8'h08;
	localparam int          B_FLAG  = 7;
	localparam int          B_IE    = 6;
	localparam int          B_CPWM  = 5;
	localparam int          B_CLKS  = 3;
	localparam int          B_MS    = 4;
	localparam int          B_ELS   = 2;
	localparam logic [15:0] MOD_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam int          NCH_DEF = 2;

	function automatic logic [7:0] ch_addr(input int n, input logic [7:0] k);
		return 8'(int'(A_CH0) + n * int'(A_CSTEP) + int'(k));
	endfunction
endpackage

// [common/cpwmt_ch_if.sv]
interface cpwmt_ch_if;
	logic [15:0] cnt;
	logic        up;
	logic        cpwm;
	logic        tick;
	logic        ovf;
	logic        wr_sc;
	logic        wr_vh;
	logic        wr_vl;
	logic        rd_sc;
	logic [7:0]  wdata;
	logic [7:0]  sc;
	logic [7:0]  vh;
	logic [7:0]  vl;
	logic        irq;
	modport timer (output cnt, up, cpwm, tick, ovf, wr_sc, wr_vh, wr_vl, rd_sc, wdata,
		input sc, vh, vl, irq);
	modport chan (input cnt, up, cpwm, tick, ovf, wr_sc, wr_vh, wr_vl, rd_sc, wdata,
		output sc, vh, vl, irq);
endinterface

// [hw/cpwmt_chan.sv]
module cpwmt_chan (
	input  wire logic  pclk,
	input  wire logic  presetn,
	cpwmt_ch_if.chan   c,
	input  wire logic  pin_in,
	output logic       pin_out,
	output logic       pin_oe
);
	typedef struct packed {
		logic        flag;
		logic        arm;
		logic        ie;
		logic [1:0]  ms;
		logic [1:0]  els;
		logic [15:0] val;
		logic [15:0] buff;
		logic        ghi;
		logic        glo;
		logic        pend;
		logic        lvl;
		logic        pin;
		logic        s1;
		logic        s2;
		logic        d;
	} cpwmt_ch_s;

	cpwmt_ch_s s;
	cpwmt_ch_s next_s;
	logic      valid;
	logic      match;
	logic      pwm;
	logic      ev;

	always_comb begin
		next_s = s;
		next_s.s1 = pin_in;
		next_s.s2 = s.s1;
		next_s.d = s.s2;
		valid = (s.val != 16'h0000) && !s.val[15];
		match = c.tick && (c.cnt == s.val);
		pwm = c.cpwm || s.ms[1];
		ev = 1'b0;
		if (c.cpwm) begin
			if (!valid) begin
				next_s.lvl = 1'b0;
			end else if (match) begin
				next_s.lvl = !c.up;
				ev = 1'b1;
			end else if (c.tick && c.cnt == 16'h0000) begin
				next_s.lvl = 1'b1;
			end
		end else begin
			case (s.ms)
				2'b00: begin
					ev = (s.els[0] && s.s2 && !s.d) || (s.els[1] && !s.s2 && s.d);
					if (ev) begin
						next_s.val = c.cnt;
					end
				end
				2'b01: begin
					if (match) begin
						ev = 1'b1;
						case (s.els)
							2'b01: next_s.lvl = !s.lvl;
							2'b10: next_s.lvl = 1'b0;
							2'b11: next_s.lvl = 1'b1;
							default: next_s.lvl = s.lvl;
						endcase
					end
				end
				default: begin
					if (match) begin
						next_s.lvl = 1'b0;
						ev = 1'b1;
					end else if (c.ovf && s.val != 16'h0000) begin
						next_s.lvl = 1'b1;
					end
				end
			endcase
		end
		if (c.wr_vh) begin
			next_s.buff[15:8] = c.wdata;
			next_s.ghi = 1'b1;
		end
		if (c.wr_vl) begin
			next_s.buff[7:0] = c.wdata;
			next_s.glo = 1'b1;
		end
		if (next_s.ghi && next_s.glo) begin
			next_s.pend = 1'b1;
			next_s.ghi = 1'b0;
			next_s.glo = 1'b0;
		end
		if (c.wr_sc) begin
			next_s.ie = c.wdata[cpwmt_pkg::B_IE];
			next_s.ms = c.wdata[cpwmt_pkg::B_MS+:2];
			next_s.els = c.wdata[cpwmt_pkg::B_ELS+:2];
			next_s.ghi = 1'b0;
			next_s.glo = 1'b0;
			next_s.pend = 1'b0;
			if (s.arm && !c.wdata[cpwmt_pkg::B_FLAG]) begin
				next_s.flag = 1'b0;
			end
			next_s.arm = 1'b0;
		end
		if (next_s.pend && (!pwm || c.ovf)) begin
			next_s.val = next_s.buff;
			next_s.pend = 1'b0;
		end
		if (c.rd_sc && s.flag) begin
			next_s.arm = 1'b1;
		end
		if (ev) begin
			next_s.flag = 1'b1;
			next_s.arm = 1'b0;
		end
		next_s.pin = pwm ? (next_s.lvl ^ next_s.els[0]) : next_s.lvl;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign c.sc = {s.flag, s.ie, s.ms, s.els, 2'b00};
	assign c.vh = s.val[15:8];
	assign c.vl = s.val[7:0];
	assign c.irq = s.flag && s.ie;
	assign pin_out = s.pin;
	assign pin_oe = (c.cpwm || s.ms != 2'b00) && s.els != 2'b00;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	flag_keep_a: assert property (ev |=> s.flag)
		else $error("Channel flag lost an event");
	zero_duty_a: assert property (c.cpwm && !valid |=> !s.lvl)
		else $error("Zero duty value drove output active");
	cpwm_edge_a: assert property (c.cpwm && valid && match |=> s.lvl == !$past(c.up))
		else $error("Center match drove wrong level");
	chan_cancel_a: assert property (c.wr_sc |=> !s.pend && !s.ghi && !s.glo)
		else $error("Channel control write kept value bytes");
endmodule // cpwmt_chan

// [hw/cpwmt_timer.sv]
// The implementer's own choices: the placing of the registers and register access over APB.
module cpwmt_timer #(
	parameter int NCH = cpwmt_pkg::NCH_DEF
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [NCH-1:0]   chan_in,
	output logic      [NCH-1:0]   chan_out,
	output logic      [NCH-1:0]   chan_oe,
	output logic                  overflow_irq,
	output logic      [NCH-1:0]   chan_irq
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        up;
		logic [15:0] md;
		logic [15:0] mbuf;
		logic        mhi;
		logic        mlo;
		logic        mpend;
		logic        ovf;
		logic        arm;
		logic        ie;
		logic        cpwm;
		logic [1:0]  clks;
		logic [31:0] rdata;
		logic        err;
	} cpwmt_tm_s;

	cpwmt_tm_s        s;
	cpwmt_tm_s        next_s;
	logic             tick;
	logic [15:0]      term;
	logic             mhalf;
	logic             setup;
	logic             acc;
	logic             wr;
	logic             rd;
	logic             wsc;
	logic             wcnt;
	logic             wmh;
	logic             wml;
	logic             ovf_evt;
	logic [7:0]       rbyte;
	logic             hit;
	logic [NCH-1:0]   in_s1;
	logic [NCH-1:0]   in_s2;
	logic [7:0]       ch_sc [NCH];
	logic [7:0]       ch_vh [NCH];
	logic [7:0]       ch_vl [NCH];

	cpwmt_ch_if ch_if [NCH] ();

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_s1 <= '0;
			in_s2 <= '0;
		end else begin
			in_s1 <= chan_in;
			in_s2 <= in_s1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign ch_if[g].cnt = s.cnt;
			assign ch_if[g].up = s.up;
			assign ch_if[g].cpwm = s.cpwm;
			assign ch_if[g].tick = tick;
			assign ch_if[g].ovf = ovf_evt;
			assign ch_if[g].wdata = pwdata[7:0];
			assign ch_if[g].wr_sc = wr && paddr == cpwmt_pkg::ch_addr(g, cpwmt_pkg::A_CSC);
			assign ch_if[g].wr_vh = wr && paddr == cpwmt_pkg::ch_addr(g, cpwmt_pkg::A_CVH);
			assign ch_if[g].wr_vl = wr && paddr == cpwmt_pkg::ch_addr(g, cpwmt_pkg::A_CVL);
			assign ch_if[g].rd_sc = rd && paddr == cpwmt_pkg::ch_addr(g, cpwmt_pkg::A_CSC);
			assign ch_sc[g] = ch_if[g].sc;
			assign ch_vh[g] = ch_if[g].vh;
			assign ch_vl[g] = ch_if[g].vl;
			assign chan_irq[g] = ch_if[g].irq;

			cpwmt_chan u_chan (
				.pclk    (pclk),
				.presetn (presetn),
				.c       (ch_if[g]),
				.pin_in  (in_s2[g]),
				.pin_out (chan_out[g]),
				.pin_oe  (chan_oe[g])
			);
		end
	endgenerate

	always_comb begin
		rbyte = 8'h00;
		hit = 1'b1;
		case (paddr)
			cpwmt_pkg::A_SC: begin
				rbyte = {s.ovf, s.ie, s.cpwm, s.clks, 3'b000};
			end
			cpwmt_pkg::A_CNTH: begin
				rbyte = s.cnt[15:8];
			end
			cpwmt_pkg::A_CNTL: begin
				rbyte = s.cnt[7:0];
			end
			cpwmt_pkg::A_MODH: begin
				rbyte = s.md[15:8];
			end
			cpwmt_pkg::A_MODL: begin
				rbyte = s.md[7:0];
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (paddr == cpwmt_pkg::ch_addr(i, cpwmt_pkg::A_CSC)) begin
				rbyte = ch_sc[i];
				hit = 1'b1;
			end
			if (paddr == cpwmt_pkg::ch_addr(i, cpwmt_pkg::A_CVH)) begin
				rbyte = ch_vh[i];
				hit = 1'b1;
			end
			if (paddr == cpwmt_pkg::ch_addr(i, cpwmt_pkg::A_CVL)) begin
				rbyte = ch_vl[i];
				hit = 1'b1;
			end
		end
	end

	always_comb begin
		next_s = s;
		tick = s.clks != 2'b00;
		term = (s.md != 16'h0000) ? s.md : cpwmt_pkg::CNT_MAX;
		mhalf = s.mhi ^ s.mlo;
		setup = psel && !penable;
		acc = psel && penable;
		wr = acc && pwrite;
		rd = acc && !pwrite;
		wsc = wr && paddr == cpwmt_pkg::A_SC;
		wcnt = wr && (paddr == cpwmt_pkg::A_CNTH || paddr == cpwmt_pkg::A_CNTL);
		wmh = wr && paddr == cpwmt_pkg::A_MODH;
		wml = wr && paddr == cpwmt_pkg::A_MODL;
		ovf_evt = 1'b0;
		if (tick) begin
			if (s.cpwm && s.md != 16'h0000) begin
				if (s.up) begin
					if (s.cnt == s.md) begin
						next_s.up = 1'b0;
						next_s.cnt = s.cnt - 16'h0001;
						ovf_evt = 1'b1;
					end else begin
						next_s.cnt = s.cnt + 16'h0001;
					end
				end else begin
					if (s.cnt == 16'h0000) begin
						next_s.up = 1'b1;
						next_s.cnt = 16'h0001;
					end else begin
						next_s.cnt = s.cnt - 16'h0001;
					end
				end
			end else begin
				next_s.up = 1'b1;
				if (s.cnt == term) begin
					next_s.cnt = 16'h0000;
					ovf_evt = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 16'h0001;
				end
			end
		end
		if (wcnt) begin
			next_s.cnt = 16'h0000;
			next_s.up = 1'b1;
		end
		if (wmh) begin
			next_s.mbuf[15:8] = pwdata[7:0];
			next_s.mhi = 1'b1;
		end
		if (wml) begin
			next_s.mbuf[7:0] = pwdata[7:0];
			next_s.mlo = 1'b1;
		end
		if (next_s.mhi && next_s.mlo) begin
			next_s.mpend = 1'b1;
			next_s.mhi = 1'b0;
			next_s.mlo = 1'b0;
		end
		if (wsc) begin
			next_s.ie = pwdata[cpwmt_pkg::B_IE];
			next_s.cpwm = pwdata[cpwmt_pkg::B_CPWM];
			next_s.clks = pwdata[cpwmt_pkg::B_CLKS+:2];
			next_s.mhi = 1'b0;
			next_s.mlo = 1'b0;
			next_s.mpend = 1'b0;
			if (s.arm && !pwdata[cpwmt_pkg::B_FLAG]) begin
				next_s.ovf = 1'b0;
			end
			next_s.arm = 1'b0;
		end
		if (next_s.mpend && (!s.cpwm || ovf_evt)) begin
			next_s.md = next_s.mbuf;
			next_s.mpend = 1'b0;
		end
		if (rd && paddr == cpwmt_pkg::A_SC && s.ovf) begin
			next_s.arm = 1'b1;
		end
		if (ovf_evt && !mhalf) begin
			next_s.ovf = 1'b1;
			next_s.arm = 1'b0;
		end
		if (setup) begin
			next_s.rdata = {24'h000000, rbyte};
			next_s.err = !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.up <= 1'b1;
			s.md <= cpwmt_pkg::MOD_RST;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = acc && s.err;
	assign overflow_irq = s.ovf && s.ie && !mhalf;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	cpwm_turn_a: assert property (
		tick && s.cpwm && s.up && s.md != 16'h0000 && s.cnt == s.md && !wcnt
		|=> !s.up && s.cnt == $past(s.md) - 16'h0001)
		else $error("Counter did not reverse at modulus");
	cpwm_floor_a: assert property (
		tick && s.cpwm && !s.up && s.md != 16'h0000 && s.cnt == 16'h0000 && !wcnt
		|=> s.up && s.cnt == 16'h0001)
		else $error("Counter did not turn up at zero");
	cpwm_ovf_a: assert property (
		tick && s.cpwm && s.up && s.md != 16'h0000 && s.cnt == s.md && !mhalf
		|=> s.ovf)
		else $error("Overflow flag missing at reversal");
	up_wrap_a: assert property (
		tick && !s.cpwm && s.cnt == term && !wcnt |=> s.cnt == 16'h0000)
		else $error("Up counter did not wrap at terminal count");
	up_ovf_a: assert property (
		tick && !s.cpwm && s.cnt == term && !mhalf |=> s.ovf)
		else $error("Overflow flag missing at wrap");
	ovf_write1_a: assert property (
		!s.ovf && !ovf_evt |=> !s.ovf)
		else $error("Overflow flag set without event");
	mod_cancel_a: assert property (
		wsc |=> !s.mhi && !s.mlo && !s.mpend)
		else $error("Control write kept modulus bytes");
	mod_half_a: assert property (
		mhalf && !s.ovf |=> !s.ovf)
		else $error("Overflow flag set during half modulus write");
	ovf_keep_a: assert property (
		wsc && ovf_evt && !mhalf |=> s.ovf)
		else $error("Overflow event lost to clear");
	irq_level_a: assert property (
		s.ovf && s.ie && !mhalf && !wsc && !wmh && !wml |=> overflow_irq)
		else $error("Overflow request dropped while flag set");
endmodule // cpwmt_timer

// [testbench/cpwmt_load.sv]
module cpwmt_load (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pin,
	input  wire logic        pin_oe,
	output logic             echo,
	output logic [31:0]      period
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cnt;
	logic        pin_q;

	// Cycles between rising edges of the drive line; undriven feedback toggles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 32'h0;
			pin_q <= 1'b0;
			period <= 32'h0;
			echo <= 1'b0;
		end else begin
			pin_q <= pin;
			cnt <= cnt + 32'h1;
			echo <= pin_oe ? pin : ~echo;
			if (pin && !pin_q) begin
				period <= cnt + 32'h1;
				cnt <= 32'h0;
			end
		end
	end
endmodule // cpwmt_load

// [testbench/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf_irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, period;
	logic [1:0]  chan_in, chan_out, chan_oe, chan_irq;
	logic [7:0]  r;
	int          miscompares, n_tests, m, v;

	cpwmt_timer #(.NCH(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
		.chan_out(chan_out), .chan_oe(chan_oe), .overflow_irq(ovf_irq), .chan_irq(chan_irq));
	cpwmt_load u_load (.pclk(pclk), .presetn(presetn), .pin(chan_out[0]),
		.pin_oe(chan_oe[0]), .echo(chan_in[0]), .period(period));
	assign chan_in[1] = 1'b0;

	always #12.5 pclk = ~pclk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk("pready", pready, 1);
			print_verdict();
		end
		r = prdata[7:0];
		if (!w && a == 8'hfc) begin
			chk("unmapped err", pslverr, 1);
			chk("unmapped data", prdata, 0);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic w16(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d[15:8]);
		apb(1'b1, a + 8'h04, d[7:0]);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(nm, r, e);
	endtask

	task automatic wait_ovf(input int lim);
		int k;
		k = 0;
		while (ovf_irq !== 1'b1 && k < lim) begin
			@(posedge pclk);
			k++;
		end
		chk("ovf irq", ovf_irq, 1);
		if (ovf_irq !== 1'b1)
			print_verdict();
	endtask

	function automatic int exp_high(input logic [15:0] val, input int md, input bit pol);
		int h;
		h = (val == 0 || val[15]) ? 0 : (int'(val) > md ? 2 * md : 2 * int'(val));
		return pol ? 2 * md - h : h;
	endfunction

	initial begin
		int h;
		logic [15:0] vals[5];
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		miscompares = 0; n_tests = 0;
		void'($urandom(32'h718acb28));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("sc reset", cpwmt_pkg::A_SC, 8'h00);
		rd("mod reset", cpwmt_pkg::A_MODL, 8'h00);
		apb(1'b0, 8'hfc, 8'h00);
		$display("test reset done");
		m = 10 + $urandom % 30;
		v = 1 + $urandom % (m - 1);
		vals = '{16'(v), 16'h0, 16'h8000 | 16'(v), 16'(m + 1), 16'(v)};
		w16(cpwmt_pkg::A_MODH, 16'(m));
		apb(1'b1, cpwmt_pkg::A_SC, 8'h28);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, cpwmt_pkg::A_CH0, i == 4 ? 8'h64 : 8'h68);
			w16(cpwmt_pkg::A_CH0 + cpwmt_pkg::A_CVH, vals[i]);
			repeat (6 * m) @(posedge pclk);
			h = 0;
			repeat (2 * m) begin
				@(posedge pclk);
				if (chan_out[0] === 1'b1)
					h++;
			end
			chk("high time", h, exp_high(vals[i], m, i == 4));
			if (i == 0) begin
				chk("period", period, 2 * m);
				chk("chan irq", chan_irq[0], 1);
			end
			$display("test duty case %0d done", i);
		end
		apb(1'b1, cpwmt_pkg::A_SC, 8'h68);
		wait_ovf(4 * m);
		// Counter restart puts the next reversal well after the clear sequence
		apb(1'b1, cpwmt_pkg::A_CNTH, 8'h00);
		rd("ovf flag", cpwmt_pkg::A_SC, 8'he8);
		apb(1'b1, cpwmt_pkg::A_SC, 8'h68);
		chk("ovf cleared", ovf_irq, 0);
		apb(1'b1, cpwmt_pkg::A_SC, 8'he8);
		rd("ovf write one", cpwmt_pkg::A_SC, 8'h68);
		$display("test overflow clear done");
		wait_ovf(4 * m);
		apb(1'b1, cpwmt_pkg::A_CNTH, 8'h00);
		apb(1'b0, cpwmt_pkg::A_SC, 8'h00);
		apb(1'b1, cpwmt_pkg::A_SC, 8'h68);
		apb(1'b1, cpwmt_pkg::A_MODH, 8'h00);
		repeat (4 * m) @(posedge pclk);
		chk("ovf held off", ovf_irq, 0);
		rd("ovf flag held", cpwmt_pkg::A_SC, 8'h68);
		apb(1'b1, cpwmt_pkg::A_SC, 8'h68);
		wait_ovf(4 * m);
		$display("test modulus coherency done");
		apb(1'b1, cpwmt_pkg::A_SC, 8'h08);
		apb(1'b1, cpwmt_pkg::A_CH0, 8'h40);
		rd("chan flag", cpwmt_pkg::A_CH0, 8'hc0);
		apb(1'b1, cpwmt_pkg::A_CH0, 8'h44);
		chk("capture clear", chan_irq[0], 0);
		repeat (8) @(posedge pclk);
		chk("capture irq", chan_irq[0], 1);
		chk("capture oe", chan_oe[0], 0);
		apb(1'b1, cpwmt_pkg::A_CH0 + cpwmt_pkg::A_CSTEP, 8'h5c);
		w16(cpwmt_pkg::A_CH0 + cpwmt_pkg::A_CSTEP + cpwmt_pkg::A_CVH, 16'(v));
		rd("compare value", cpwmt_pkg::A_CH0 + cpwmt_pkg::A_CSTEP + cpwmt_pkg::A_CVL, 8'(v));
		repeat (2 * m + 4) @(posedge pclk);
		chk("compare pin", chan_out[1], 1);
		chk("compare oe", chan_oe[1], 1);
		chk("compare irq", chan_irq[1], 1);
		$display("test capture and compare done");
		print_verdict();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		print_verdict();
	end
endmodule // testbench
